/* hw/plk_link.sv */
// Top of the controller link: status flags, request handshake and timeouts.
`timescale 1ns/1ps
module plk_link #(
   parameter longint TIMEOUT_TICKS = plk_pkg::TIMEOUT_TICKS_DEFAULT,
   parameter int NUM_SLAVES = 3
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [4:0] module_count_in,
   input wire logic module_count_valid,
   input wire logic addr_gap,
   input wire logic internal_error,
   input wire logic is_slave,
   input wire logic [1:0] slave_index,
   input wire logic [NUM_SLAVES:0] hub_seen,
   input wire logic [NUM_SLAVES:0] hub_activity,
   input wire logic master_fail,
   input wire logic master_sending,
   input wire logic startup_done,
   input wire logic monitor_written,
   input wire logic req_we,
   input wire logic [7:0] req_wdata,
   input wire logic access_ok,
   input wire logic access_fail,
   input wire logic group_done,
   input wire logic group_fail,
   input wire logic cmd_we,
   input wire logic [1:0] run_in,
   input wire logic [1:0] tune_in,
   output logic [7:0] transfer_status,
   output logic [7:0] transfer_request_bits,
   output logic [4:0] module_count,
   output logic [NUM_SLAVES:0] hub_recognized,
   output logic own_recognized,
   output logic [3:0] comm_error,
   output logic comm_available,
   output logic fetch_active,
   output logic store_active,
   output logic monitor_enable,
   output logic slave_tx_enable,
   output plk_pkg::plk_run_e run_cmd,
   output plk_pkg::plk_tune_e tune_cmd
);
   localparam int TICKS = int'(TIMEOUT_TICKS);

   // ***************************************************************
   // State
   // ***************************************************************
   plk_pkg::plk_state_e state_reg;
   plk_pkg::plk_state_e state_next;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [1:0] req_reg;
   logic [1:0] req_next;
   logic [4:0] count_reg;
   logic [4:0] count_next;
   logic [NUM_SLAVES:0] recog_reg;
   logic [NUM_SLAVES:0] recog_next;
   logic [3:0] err_reg;
   logic [3:0] err_next;
   logic avail_reg;
   logic avail_next;
   logic slave_hold_reg;
   logic slave_hold_next;
   logic link_timeout;
   logic good_long;
   logic [NUM_SLAVES:0] hub_timeout;
   logic slave_any_timeout;
   logic hubs_multi;
   logic access_bad;

   // ***************************************************************
   // Timers
   // ***************************************************************
   // Two timers on the controller link (silence and good runs) plus one per hub.
   plk_timer #(.LIMIT(TICKS)) u_link_timer (
      .clock(clock),
      .resetn(resetn),
      .activity(access_ok),
      .expired(link_timeout)
   );

   // Runs of good accesses: restarted by every failure, expires after three good seconds.
   plk_timer #(.LIMIT(TICKS)) u_good_timer (
      .clock(clock),
      .resetn(resetn),
      .activity(access_bad),
      .expired(good_long)
   );

   for (genvar g = 0; g <= NUM_SLAVES; g++) begin : g_hub
      plk_timer #(.LIMIT(TICKS)) u_hub_timer (
         .clock(clock),
         .resetn(resetn),
         .activity(hub_activity[g]),
         .expired(hub_timeout[g])
      );
   end

   plk_cmd u_cmd (
      .clock(clock),
      .resetn(resetn),
      .cmd_we(cmd_we),
      .run_in(run_in),
      .tune_in(tune_in),
      .run_cmd(run_cmd),
      .tune_cmd(tune_cmd)
   );

   // Counts how many hubs are present; slave timeouts only matter with two or more.
   function automatic logic [2:0] ones(input logic [NUM_SLAVES:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i <= NUM_SLAVES; i++) begin
         n = n + 3'(v[i]);
      end
      return n;
   endfunction

   assign hubs_multi = (ones(recog_reg) >= 3'h2);
   assign slave_any_timeout = |(hub_timeout[NUM_SLAVES:1] & recog_reg[NUM_SLAVES:1]);
   // A failed group transfer or a silent link is a failed access as well, so either one
   // restarts the run of good accesses; otherwise the error would clear a cycle later.
   assign access_bad = access_fail || link_timeout
      || (group_fail && (fetch_active || store_active));

   // ***************************************************************
   // Transfer sequencer
   // ***************************************************************
   // The request bits are held until the transfer resolves, so the controller
   // sees zero only when the device is finished.
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      status_next = status_reg;
      avail_next = avail_reg;
      if (req_we && state_reg == plk_pkg::PLK_ST_IDLE) begin
         req_next = req_wdata[1:0];
      end
      case (state_reg)
         plk_pkg::PLK_ST_STARTUP: begin
            if (startup_done && monitor_written) begin
               avail_next = 1'b1;
               state_next = plk_pkg::PLK_ST_IDLE;
            end
         end
         plk_pkg::PLK_ST_IDLE: begin
            if (req_reg[plk_pkg::REQ_WRITE_BIT]) begin
               status_next[plk_pkg::STS_WDONE_BIT] = 1'b0;
               status_next[plk_pkg::STS_ERR_BIT] = 1'b0;
               state_next = plk_pkg::PLK_ST_FETCH;
            end else if (req_reg[plk_pkg::REQ_READ_BIT]) begin
               status_next[plk_pkg::STS_RDONE_BIT] = 1'b0;
               status_next[plk_pkg::STS_ERR_BIT] = 1'b0;
               state_next = plk_pkg::PLK_ST_STORE;
            end
         end
         plk_pkg::PLK_ST_FETCH: begin
            if (group_fail) begin
               status_next[plk_pkg::STS_ERR_BIT] = 1'b1;
               req_next[plk_pkg::REQ_WRITE_BIT] = 1'b0;
               state_next = plk_pkg::PLK_ST_DONE;
            end else if (group_done) begin
               status_next[plk_pkg::STS_WDONE_BIT] = 1'b1;
               req_next[plk_pkg::REQ_WRITE_BIT] = 1'b0;
               state_next = plk_pkg::PLK_ST_DONE;
            end
         end
         plk_pkg::PLK_ST_STORE: begin
            if (group_fail) begin
               status_next[plk_pkg::STS_ERR_BIT] = 1'b1;
               req_next[plk_pkg::REQ_READ_BIT] = 1'b0;
               state_next = plk_pkg::PLK_ST_DONE;
            end else if (group_done) begin
               status_next[plk_pkg::STS_RDONE_BIT] = 1'b1;
               req_next[plk_pkg::REQ_READ_BIT] = 1'b0;
               state_next = plk_pkg::PLK_ST_DONE;
            end
         end
         default: begin
            state_next = plk_pkg::PLK_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= plk_pkg::PLK_ST_STARTUP;
         req_reg <= plk_pkg::REQUEST_RESET[1:0];
         status_reg <= plk_pkg::STATUS_RESET;
         avail_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         status_reg <= status_next;
         avail_reg <= avail_next;
      end
   end

   // ***************************************************************
   // Module count, recognition and error flags
   // ***************************************************************
   // Error flags are sticky; only the access error clears itself, and a new
   // failure in the same cycle wins over the clear by priority, and it also restarts the good timer.
   always_comb begin
      count_next = count_reg;
      recog_next = recog_reg | hub_seen;
      err_next = err_reg;
      slave_hold_next = slave_hold_reg;
      if (module_count_valid) begin
         count_next = module_count_in;
      end
      if (access_fail || link_timeout) begin
         err_next[plk_pkg::ERR_ACCESS_BIT] = 1'b1;
      end else if (good_long) begin
         err_next[plk_pkg::ERR_ACCESS_BIT] = 1'b0;
      end
      if (hubs_multi && slave_any_timeout) begin
         err_next[plk_pkg::ERR_SLAVE_BIT] = 1'b1;
      end
      if (internal_error || addr_gap) begin
         err_next[plk_pkg::ERR_INTERNAL_BIT] = 1'b1;
      end
      if (master_fail || hub_timeout[0]) begin
         err_next[plk_pkg::ERR_MASTER_BIT] = 1'b1;
      end
      if (group_fail && (fetch_active || store_active)) begin
         err_next[plk_pkg::ERR_ACCESS_BIT] = 1'b1;
      end
      if (is_slave && hub_timeout[0]) begin
         slave_hold_next = 1'b1;
      end else if (master_sending) begin
         slave_hold_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_reg <= plk_pkg::MODULE_COUNT_RESET;
         recog_reg <= '0;
         err_reg <= 4'h0;
         slave_hold_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         recog_reg <= recog_next;
         err_reg <= err_next;
         slave_hold_reg <= slave_hold_next;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign transfer_status = status_reg;
   assign transfer_request_bits = {6'h00, req_reg};
   assign module_count = count_reg;
   assign hub_recognized = recog_reg;
   assign own_recognized = recog_reg[slave_index];
   assign comm_error = err_reg;
   assign comm_available = avail_reg;
   assign fetch_active = (state_reg == plk_pkg::PLK_ST_FETCH);
   assign store_active = (state_reg == plk_pkg::PLK_ST_STORE);
   // Monitoring writes pause for the whole transfer and before startup ends.
   assign monitor_enable = avail_reg && !fetch_active && !store_active;
   assign slave_tx_enable = !slave_hold_reg;

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_WRITE_DONE: assert property (@(posedge clock) disable iff (!resetn)
      fetch_active && group_done && !group_fail |=> transfer_status[1]
      && !transfer_request_bits[0]) else $error("write done not flagged");
   AST_READ_DONE: assert property (@(posedge clock) disable iff (!resetn)
      store_active && group_done && !group_fail |=> transfer_status[2]
      && !transfer_request_bits[1]) else $error("read done not flagged");
   AST_MON_PAUSE: assert property (@(posedge clock) disable iff (!resetn)
      (fetch_active || store_active) |-> !monitor_enable) else $error("monitor not paused");
   AST_FAIL_FLAG: assert property (@(posedge clock) disable iff (!resetn)
      (fetch_active || store_active) && group_fail |=> comm_error[0] [*2])
      else $error("failure not flagged");
   AST_ACCESS_SET: assert property (@(posedge clock) disable iff (!resetn)
      access_fail |=> comm_error[0]) else $error("access error not set");
   AST_INTERNAL: assert property (@(posedge clock) disable iff (!resetn)
      addr_gap |=> comm_error[2]) else $error("internal timeout not set");
   AST_MASTER: assert property (@(posedge clock) disable iff (!resetn)
      master_fail |=> comm_error[3]) else $error("master timeout not set");
   AST_STICKY_ERR: assert property (@(posedge clock) disable iff (!resetn)
      $fell(comm_error[3]) |-> 1'b0) else $error("master timeout cleared");
   AST_FETCH_START: assert property (@(posedge clock) disable iff (!resetn)
      state_reg == plk_pkg::PLK_ST_IDLE && transfer_request_bits[0] |=> fetch_active)
      else $error("write request not started");
   AST_AVAIL: assert property (@(posedge clock) disable iff (!resetn)
      !comm_available && startup_done && monitor_written |=> comm_available)
      else $error("availability not set");
   AST_SLAVE_STOP: assert property (@(posedge clock) disable iff (!resetn)
      is_slave && hub_timeout[0] |=> !slave_tx_enable) else $error("slave kept sending");
   AST_COUNT: assert property (@(posedge clock) disable iff (!resetn)
      module_count_valid |=> module_count == $past(module_count_in))
      else $error("module count not taken");
   AST_REQ_HELD: assert property (@(posedge clock) disable iff (!resetn)
      state_reg != plk_pkg::PLK_ST_IDLE && !group_done && !group_fail
      |=> $stable(transfer_request_bits)) else $error("request changed outside idle");
endmodule // plk_link

/* hw/plk_pkg.sv */
// Package of constants and types for the controller link status and transfer block.
package plk_pkg;
   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int STS_ERR_BIT = 0;
   localparam int STS_WDONE_BIT = 1;
   localparam int STS_RDONE_BIT = 2;
   localparam int REQ_WRITE_BIT = 0;
   localparam int REQ_READ_BIT = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] REQUEST_RESET = 8'h00;
   localparam int ERR_ACCESS_BIT = 0;
   localparam int ERR_SLAVE_BIT = 1;
   localparam int ERR_INTERNAL_BIT = 2;
   localparam int ERR_MASTER_BIT = 3;
   localparam logic [4:0] MODULE_COUNT_RESET = 5'h00;
   localparam logic [1:0] GROUP_CMD_RESET = 2'h2;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int TIMEOUT_SECONDS = 3;
   localparam int CLOCK_HZ = 250000000;
   localparam longint TIMEOUT_TICKS_DEFAULT = longint'(TIMEOUT_SECONDS) * longint'(CLOCK_HZ);
   // ***************************************************************
   // Commands and states
   // ***************************************************************
   typedef enum logic [1:0] {
      PLK_RUN_ALL = 2'h0,
      PLK_STOP_ALL = 2'h1,
      PLK_RUN_SELECT = 2'h2
   } plk_run_e;
   typedef enum logic [1:0] {
      PLK_TUNE_STOP = 2'h0,
      PLK_TUNE_ALL = 2'h1,
      PLK_TUNE_SELECT = 2'h2
   } plk_tune_e;
   typedef enum logic [2:0] {
      PLK_ST_STARTUP = 3'h0,
      PLK_ST_IDLE = 3'h1,
      PLK_ST_FETCH = 3'h3,
      PLK_ST_STORE = 3'h2,
      PLK_ST_DONE = 3'h6
   } plk_state_e;
endpackage

/* hw/plk_timer.sv */
// Saturating activity timer that flags a silence longer than its limit.
`timescale 1ns/1ps
module plk_timer #(
   parameter int LIMIT = 750000000
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic activity,
   output logic expired
);
   localparam int CW = $clog2(LIMIT + 2);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;

   // Count idle ticks; any activity restarts, and the count holds once over the limit.
   always_comb begin
      count_next = count_reg;
      if (activity) begin
         count_next = '0;
      end else if (count_reg <= LIM) begin
         count_next = count_reg + CW'(1);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // Strictly more than the limit counts as a timeout.
   assign expired = (count_reg > LIM);

   AST_TIMER_EXPIRE: assert property (@(posedge clock) disable iff (!resetn)
      activity |=> !expired) else $error("timer expired right after activity");
endmodule // plk_timer

/* hw/plk_cmd.sv */
// Group run/stop and autotuning command holding with broadcast outputs.
`timescale 1ns/1ps
module plk_cmd (
   input wire logic clock,
   input wire logic resetn,
   input wire logic cmd_we,
   input wire logic [1:0] run_in,
   input wire logic [1:0] tune_in,
   output plk_pkg::plk_run_e run_cmd,
   output plk_pkg::plk_tune_e tune_cmd
);
   plk_pkg::plk_run_e run_reg;
   plk_pkg::plk_run_e run_next;
   plk_pkg::plk_tune_e tune_reg;
   plk_pkg::plk_tune_e tune_next;

   // Code 3 is not a defined command, so such a write leaves the old value.
   always_comb begin
      run_next = run_reg;
      tune_next = tune_reg;
      if (cmd_we && run_in != 2'h3) begin
         run_next = plk_pkg::plk_run_e'(run_in);
      end
      if (cmd_we && tune_in != 2'h3) begin
         tune_next = plk_pkg::plk_tune_e'(tune_in);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_reg <= plk_pkg::PLK_RUN_SELECT;
         tune_reg <= plk_pkg::PLK_TUNE_SELECT;
      end else begin
         run_reg <= run_next;
         tune_reg <= tune_next;
      end
   end

   // Broadcast to all attached modules straight from the held values.
   assign run_cmd = run_reg;
   assign tune_cmd = tune_reg;

   AST_CMD_LEGAL: assert property (@(posedge clock) disable iff (!resetn)
      run_cmd != 2'h3 && tune_cmd != 2'h3) else $error("illegal group command");
endmodule // plk_cmd

/* tb/plk_ctrl_model.sv */
// Behavioural model of the external controller side that answers setting group transfers.
`timescale 1ns/1ps
module plk_ctrl_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic fetch_active,
   input wire logic store_active,
   input wire logic fail_next,
   input wire logic [3:0] stall,
   output logic group_done,
   output logic group_fail
);
   // ***************************************************************
   // Transfer answer
   // ***************************************************************
   // The model waits a chosen stall, then reports one result pulse; it re-arms after a fixed two-cycle pause, without
   // watching the active flag, which the block has dropped by then, so one transfer never gets two answers.
   initial begin
      group_done = 1'b0;
      group_fail = 1'b0;
      forever begin
         @(negedge clock);
         if (resetn && (fetch_active || store_active)) begin
            repeat (stall) @(negedge clock);
            group_fail = fail_next;
            group_done = !fail_next;
            @(negedge clock);
            group_done = 1'b0;
            group_fail = 1'b0;
            @(negedge clock);
         end
      end
   end
endmodule // plk_ctrl_model

/* tb/plk_link_tb_top.sv */
// Self-checking testbench for the controller link status and transfer block.
`timescale 1ns/1ps
module plk_link_tb_top;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] module_count_in = 5'h00;
   logic module_count_valid = 1'b0, addr_gap = 1'b0, internal_error = 1'b0, is_slave = 1'b0;
   logic [1:0] slave_index = 2'h2;
   logic [3:0] hub_seen = 4'h0, hub_activity = 4'hF;
   logic master_fail = 1'b0, master_sending = 1'b0, startup_done = 1'b0;
   logic monitor_written = 1'b0, req_we = 1'b0, access_ok = 1'b1, access_fail = 1'b0;
   logic [7:0] req_wdata = 8'h00;
   logic cmd_we = 1'b0, fail_next = 1'b0;
   logic [1:0] run_in = 2'h2, tune_in = 2'h2;
   logic [3:0] stall = 4'h6;
   logic group_done, group_fail, own_recognized, comm_available;
   logic fetch_active, store_active, monitor_enable, slave_tx_enable;
   logic [7:0] transfer_status, transfer_request_bits;
   logic [4:0] module_count;
   logic [3:0] hub_recognized, comm_error;
   plk_pkg::plk_run_e run_cmd;
   plk_pkg::plk_tune_e tune_cmd;
   int fails = 0;
   int tests_run = 0;
   // Clock of 4 ns period.
   always #2 clock = ~clock;
   // ***************************************************************
   // Instances
   // ***************************************************************
   plk_link #(.TIMEOUT_TICKS(20), .NUM_SLAVES(3)) plk_link_inst (
      .clock(clock), .resetn(resetn), .module_count_in(module_count_in),
      .module_count_valid(module_count_valid), .addr_gap(addr_gap),
      .internal_error(internal_error), .is_slave(is_slave), .slave_index(slave_index),
      .hub_seen(hub_seen), .hub_activity(hub_activity), .master_fail(master_fail),
      .master_sending(master_sending), .startup_done(startup_done),
      .monitor_written(monitor_written), .req_we(req_we), .req_wdata(req_wdata),
      .access_ok(access_ok), .access_fail(access_fail), .group_done(group_done),
      .group_fail(group_fail), .cmd_we(cmd_we), .run_in(run_in), .tune_in(tune_in),
      .transfer_status(transfer_status), .transfer_request_bits(transfer_request_bits),
      .module_count(module_count), .hub_recognized(hub_recognized),
      .own_recognized(own_recognized), .comm_error(comm_error),
      .comm_available(comm_available), .fetch_active(fetch_active),
      .store_active(store_active), .monitor_enable(monitor_enable),
      .slave_tx_enable(slave_tx_enable), .run_cmd(run_cmd), .tune_cmd(tune_cmd));
   plk_ctrl_model plk_ctrl_model_inst (
      .clock(clock), .resetn(resetn), .fetch_active(fetch_active),
      .store_active(store_active), .fail_next(fail_next), .stall(stall),
      .group_done(group_done), .group_fail(group_fail));
   // ***************************************************************
   // Tasks
   // ***************************************************************
   // Verdict and end of run; every exit path comes through here.
   task close_out();
      if (fails == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Compare one value, widened to a byte by the caller.
   task check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Selects a design flag for the bounded wait.
   function automatic logic pick(input int sel);
      case (sel)
         0: return fetch_active;
         1: return store_active;
         2: return monitor_enable;
         3: return comm_available;
         4: return comm_error[0];
         5: return comm_error[1];
         6: return comm_error[3];
         7: return slave_tx_enable;
         default: return comm_error[2];
      endcase
   endfunction
   // Waits at falling edges, where outputs are settled; a used-up bound ends the run.
   task wait_for(input int sel, input logic val);
      int n;
      n = 0;
      while (pick(sel) !== val) begin
         @(negedge clock);
         n++;
         if (n > 200) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, pick(sel), val);
            close_out();
         end
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // One controller write of the request byte, one cycle wide.
   task send_req(input logic [7:0] d);
      @(negedge clock);
      req_wdata = d;
      req_we = 1'b1;
      @(negedge clock);
      req_we = 1'b0;
   endtask
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      tick(12);
      resetn = 1'b1;
      tick(1);
      check(transfer_status, 8'h00);
      check(transfer_request_bits, 8'h00);
      check(8'(module_count), 8'h00);
      check(8'(hub_recognized), 8'h00);
      check(8'(comm_error), 8'h00);
      check(8'(run_cmd), 8'h02);
      check(8'(tune_cmd), 8'h02);
      // A request before the link is available is dropped.
      send_req(8'h01);
      check(transfer_request_bits, 8'h00);
      startup_done = 1'b1;
      tick(3);
      check(8'(comm_available), 8'h00);
      monitor_written = 1'b1;
      wait_for(3, 1'b1);
      module_count_in = 5'h1F;
      module_count_valid = 1'b1;
      hub_seen = 4'h5;
      tick(1);
      module_count_valid = 1'b0;
      hub_seen = 4'h0;
      tick(1);
      check(8'(module_count), 8'h1F);
      check(8'(hub_recognized), 8'h05);
      check(8'(own_recognized), 8'h01);
      slave_index = 2'h1;
      tick(1);
      check(8'(own_recognized), 8'h00);
      // Write transfer with a slow answer and a refused request in mid-transfer.
      send_req(8'h01);
      check(transfer_request_bits, 8'h01);
      wait_for(0, 1'b1);
      check(8'(monitor_enable), 8'h00);
      send_req(8'h02);
      check(transfer_request_bits, 8'h01);
      wait_for(0, 1'b0);
      check(transfer_status, 8'h02);
      check(transfer_request_bits, 8'h00);
      wait_for(2, 1'b1);
      // Read transfer answered at once.
      stall = 4'h0;
      send_req(8'h02);
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      check(transfer_status, 8'h06);
      check(transfer_request_bits, 8'h00);
      // Both requests: write runs first, read follows.
      send_req(8'h03);
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
      check(transfer_request_bits, 8'h02);
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      check(transfer_status, 8'h06);
      // Failed read sets the error bits; the access error clears after a quiet spell.
      fail_next = 1'b1;
      send_req(8'h02);
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      fail_next = 1'b0;
      tick(1);
      check(transfer_status & 8'h05, 8'h01);
      check(8'(comm_error[0]), 8'h01);
      access_fail = 1'b1;
      tick(1);
      access_fail = 1'b0;
      tick(12);
      check(8'(comm_error[0]), 8'h01);
      wait_for(4, 1'b0);
      // Group commands, every code, and the ignored code.
      for (int i = 0; i < 3; i++) begin
         run_in = 2'(i);
         tune_in = 2'(2 - i);
         cmd_we = 1'b1;
         tick(1);
         cmd_we = 1'b0;
         tick(1);
         check(8'(run_cmd), 8'(i));
         check(8'(tune_cmd), 8'(2 - i));
      end
      run_in = 2'h3;
      tune_in = 2'h3;
      cmd_we = 1'b1;
      tick(1);
      cmd_we = 1'b0;
      tick(1);
      check(8'(run_cmd), 8'h02);
      check(8'(tune_cmd), 8'h00);
      // Timeouts: slave hub silent, then master hub silent.
      is_slave = 1'b1;
      hub_seen = 4'h3;
      tick(1);
      hub_seen = 4'h0;
      check(8'(hub_recognized), 8'h07);
      hub_activity = 4'hD;
      tick(12);
      check(8'(comm_error[1]), 8'h00);
      wait_for(5, 1'b1);
      hub_activity = 4'hC;
      wait_for(7, 1'b0);
      wait_for(6, 1'b1);
      hub_activity = 4'hF;
      tick(3);
      check(8'(slave_tx_enable), 8'h00);
      master_sending = 1'b1;
      tick(1);
      master_sending = 1'b0;
      wait_for(7, 1'b1);
      internal_error = 1'b1;
      tick(1);
      internal_error = 1'b0;
      wait_for(8, 1'b1);
      // Reset in mid-run, then address gap and master failure.
      resetn = 1'b0;
      tick(2);
      check(8'(comm_error), 8'h00);
      resetn = 1'b1;
      tick(1);
      addr_gap = 1'b1;
      master_fail = 1'b1;
      tick(1);
      addr_gap = 1'b0;
      master_fail = 1'b0;
      wait_for(8, 1'b1);
      wait_for(6, 1'b1);
      close_out();
   end
endmodule // plk_link_tb_top
